// >>> hw/ocmp_channel.sv
/*
 * output compare channel: timer, two compare values, mode sequencing, trigger status,
 * sticky match interrupts, apb register slave.
 * assumes one clock pclk, asynchronous active-low presetn and a clock enable from the
 * same domain; the compare pin drives an external load only.
 */

// guarded, so a second inclusion after the package is harmless
`include "ocmp_defines.svh"

module ocmp_channel (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire ocmp_pkg::apb_req_t apb_req,
	output ocmp_pkg::apb_rsp_t apb_rsp,
	input wire logic trig_stat_set,
	output logic compare_output_pin,
	output logic trig_gen_clock,
	output logic trig_status_flag,
	output logic irq
);
	import ocmp_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// state
	state_t st_r; // registered state
	state_t st_nxt; // next state

	// helpers
	mode_t mode; // current mode
	logic pwm_mode; // either pwm mode
	logic pri_hit; // timer equals primary
	logic sec_hit; // timer equals secondary
	logic zero_hit; // timer at zero
	logic wr_acc; // write access phase
	logic rd_acc; // read access phase
	logic wr_ctrl; // control one written
	logic [31:0] rdata; // read mux

	// is a mode one of the pwm codes
	function automatic logic is_pwm(input mode_t m);
		is_pwm = (m == `MODE_PWM_EDGE) || (m == `MODE_PWM_CENTER);
	endfunction

	// initial pin level of a mode, used at mode write
	function automatic logic init_level(input mode_t m);
		init_level = (m == `MODE_SS_LOW);
	endfunction

	assign mode = st_r.ctrl_one[`MODE_MSB:`MODE_LSB];
	assign pwm_mode = is_pwm(mode);
	assign pri_hit = st_r.timer == st_r.pri_active;
	assign sec_hit = st_r.timer == st_r.sec_active;
	assign zero_hit = st_r.timer == `TIMER_RESET;
	assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign rd_acc = apb_req.psel && apb_req.penable && !apb_req.pwrite;
	assign wr_ctrl = wr_acc && (apb_req.paddr == `OFS_CTRL_ONE);

	////////////////////////////////////////////////////////////////////////////////
	// read mux, unmapped reads give zero and slverr
	always_comb begin
		rdata = 32'h0000_0000;
		if (apb_req.paddr == `OFS_CTRL_ONE) begin
			rdata = {16'h0000, st_r.ctrl_one};
		end else if (apb_req.paddr == `OFS_CTRL_TWO) begin
			rdata[`TRIG_STAT_BIT] = st_r.trig_stat;
		end else if (apb_req.paddr == `OFS_PRIMARY) begin
			rdata = {16'h0000, st_r.pri_buf};
		end else if (apb_req.paddr == `OFS_SECONDARY) begin
			rdata = {16'h0000, st_r.sec_buf};
		end else if (apb_req.paddr == `OFS_TIMER) begin
			rdata = {16'h0000, st_r.timer};
		end else if (apb_req.paddr == `OFS_IRQ_STAT) begin
			rdata[`IRQ_WIDTH-1:0] = st_r.irq_stat;
		end else if (apb_req.paddr == `OFS_IRQ_MASK) begin
			rdata[`IRQ_WIDTH-1:0] = st_r.irq_mask;
		end
	end

	// unmapped address decode
	function automatic logic mapped(input logic [11:0] a);
		mapped = (a == `OFS_CTRL_ONE) || (a == `OFS_CTRL_TWO) || (a == `OFS_PRIMARY) ||
			(a == `OFS_SECONDARY) || (a == `OFS_TIMER) || (a == `OFS_IRQ_STAT) ||
			(a == `OFS_IRQ_MASK);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		st_nxt = st_r;
		// one-cycle apb answer: pready pulses in the access phase
		st_nxt.rsp.pready = apb_req.psel && apb_req.penable && !st_r.rsp.pready;
		st_nxt.rsp.pslverr = apb_req.psel && apb_req.penable && !st_r.rsp.pready && !mapped(apb_req.paddr);
		st_nxt.rsp.prdata = rd_acc ? rdata : 32'h0000_0000;
		st_nxt.trig_clk = 1'b0;

		// free running timer, enable bit and a mode other than off gate it
		if (st_r.ctrl_one[`TMR_EN_BIT] && mode != `MODE_OFF) begin
			st_nxt.timer = st_r.timer + 16'h0001;
			// edge pwm period ends at secondary match
			if (mode == `MODE_PWM_EDGE && sec_hit) begin
				st_nxt.timer = `TIMER_RESET;
			end
		end

		// pwm loads buffered values at period start only
		if (pwm_mode && zero_hit) begin
			st_nxt.pri_active = st_r.pri_buf;
			st_nxt.sec_active = st_r.sec_buf;
		end

		// mode sequencing on compare events
		case (mode)
			`MODE_OFF: begin
				st_nxt.out = 1'b0;
				st_nxt.phase = PH_IDLE;
			end
			`MODE_SS_HIGH, `MODE_SS_LOW: begin
				if (st_r.phase == PH_WAIT_PRI && pri_hit) begin
					st_nxt.out = (mode == `MODE_SS_HIGH);
					st_nxt.phase = PH_DONE;
				end
			end
			`MODE_TOGGLE: begin
				if (pri_hit) begin
					st_nxt.out = !st_r.out;
				end
			end
			`MODE_DC_SINGLE, `MODE_DC_CONT: begin
				if (st_r.phase == PH_WAIT_PRI && pri_hit) begin
					st_nxt.out = !st_r.out;
					st_nxt.phase = PH_WAIT_SEC;
				end else if (st_r.phase == PH_WAIT_SEC && sec_hit) begin
					st_nxt.out = !st_r.out;
					// single shot stops after one pulse, continuous rearms
					st_nxt.phase = (mode == `MODE_DC_CONT) ? PH_WAIT_PRI : PH_DONE;
				end
			end
			`MODE_PWM_EDGE: begin
				if (pri_hit) begin
					st_nxt.out = 1'b0;
				end else if (zero_hit) begin
					st_nxt.out = 1'b1;
				end
			end
			default: begin
				// centre pwm
				if (sec_hit) begin
					st_nxt.out = 1'b0;
				end else if (pri_hit) begin
					st_nxt.out = 1'b1;
				end
			end
		endcase

		// one trigger clock pulse per primary compare event
		if (mode != `MODE_OFF && pri_hit && st_r.ctrl_one[`TMR_EN_BIT]) begin
			st_nxt.trig_clk = 1'b1;
		end

		// trigger status: software clear first, then hardware clear, then set wins
		if (wr_acc && apb_req.paddr == `OFS_CTRL_TWO && !apb_req.pwdata[`TRIG_STAT_BIT]) begin
			st_nxt.trig_stat = 1'b0;
		end
		if (st_r.ctrl_one[`TRIG_MODE_BIT] && sec_hit) begin
			st_nxt.trig_stat = 1'b0;
		end
		if (trig_stat_set) begin
			st_nxt.trig_stat = 1'b1;
		end

		// sticky match status; read clears, a new event wins
		if (rd_acc && !st_r.rsp.pready && apb_req.paddr == `OFS_IRQ_STAT) begin
			st_nxt.irq_stat = '0;
		end
		if (mode != `MODE_OFF && st_r.ctrl_one[`TMR_EN_BIT]) begin
			st_nxt.irq_stat[`IRQ_PRI_BIT] = st_nxt.irq_stat[`IRQ_PRI_BIT] | pri_hit;
			st_nxt.irq_stat[`IRQ_SEC_BIT] = st_nxt.irq_stat[`IRQ_SEC_BIT] | sec_hit;
		end

		// register writes, taken once in the access phase
		if (wr_acc && !st_r.rsp.pready) begin
			if (apb_req.paddr == `OFS_CTRL_ONE) begin
				st_nxt.ctrl_one = apb_req.pwdata[15:0];
			end else if (apb_req.paddr == `OFS_PRIMARY) begin
				st_nxt.pri_buf = apb_req.pwdata[15:0];
				// direct effect outside pwm
				if (!is_pwm(mode)) begin
					st_nxt.pri_active = apb_req.pwdata[15:0];
				end
			end else if (apb_req.paddr == `OFS_SECONDARY) begin
				st_nxt.sec_buf = apb_req.pwdata[15:0];
				if (!is_pwm(mode)) begin
					st_nxt.sec_active = apb_req.pwdata[15:0];
				end
			end else if (apb_req.paddr == `OFS_TIMER) begin
				st_nxt.timer = apb_req.pwdata[15:0];
			end else if (apb_req.paddr == `OFS_IRQ_MASK) begin
				st_nxt.irq_mask = apb_req.pwdata[`IRQ_WIDTH-1:0];
			end
		end

		// a write that changes the mode forces the initial level and rearms the sequence
		if (wr_ctrl && !st_r.rsp.pready &&
			apb_req.pwdata[`MODE_MSB:`MODE_LSB] != mode) begin
			st_nxt.out = init_level(apb_req.pwdata[`MODE_MSB:`MODE_LSB]);
			st_nxt.phase = PH_WAIT_PRI;
		end

		st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register, frozen when the clock enable is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

	assign apb_rsp = st_r.rsp;
	assign compare_output_pin = st_r.out;
	assign trig_gen_clock = st_r.trig_clk;
	assign trig_status_flag = st_r.trig_stat;
	assign irq = st_r.irq;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_pri_match;
		clk_en && mode == `MODE_PWM_CENTER && pri_hit && !sec_hit && !wr_ctrl;
	endsequence

	property p_center_high;
		@(posedge pclk) disable iff (!presetn) s_pri_match |=> compare_output_pin;
	endproperty
	a_center_high: assert property (p_center_high) else $error("centre pwm not high on primary");

	property p_center_low;
		@(posedge pclk) disable iff (!presetn)
			clk_en && mode == `MODE_PWM_CENTER && sec_hit && !wr_ctrl |=> !compare_output_pin;
	endproperty
	a_center_low: assert property (p_center_low) else $error("centre pwm not low on secondary");

	property p_edge_low;
		@(posedge pclk) disable iff (!presetn)
			clk_en && mode == `MODE_PWM_EDGE && pri_hit && !wr_ctrl |=> !compare_output_pin;
	endproperty
	a_edge_low: assert property (p_edge_low) else $error("edge pwm not low on primary");

	property p_toggle;
		@(posedge pclk) disable iff (!presetn)
			clk_en && mode == `MODE_TOGGLE && pri_hit && !wr_ctrl |=> compare_output_pin != $past(compare_output_pin);
	endproperty
	a_toggle: assert property (p_toggle) else $error("single compare did not toggle");

	property p_off;
		@(posedge pclk) disable iff (!presetn)
			clk_en && mode == `MODE_OFF && !wr_ctrl |=> !compare_output_pin;
	endproperty
	a_off: assert property (p_off) else $error("disabled channel drives high");

	property p_hold_status;
		@(posedge pclk) disable iff (!presetn)
			trig_status_flag && !st_r.ctrl_one[`TRIG_MODE_BIT] && !(wr_acc && apb_req.paddr == `OFS_CTRL_TWO)
			|=> trig_status_flag;
	endproperty
	a_hold_status: assert property (p_hold_status) else $error("status cleared by hardware");

	property p_auto_clear;
		@(posedge pclk) disable iff (!presetn)
			clk_en && st_r.ctrl_one[`TRIG_MODE_BIT] && sec_hit && !trig_stat_set |=> !trig_status_flag;
	endproperty
	a_auto_clear: assert property (p_auto_clear) else $error("status not cleared on secondary match");

	property p_init_level;
		@(posedge pclk) disable iff (!presetn)
			clk_en && wr_ctrl && !st_r.rsp.pready && apb_req.pwdata[2:0] == `MODE_SS_LOW && mode != `MODE_SS_LOW
			|=> compare_output_pin;
	endproperty
	a_init_level: assert property (p_init_level) else $error("initial high level not applied");

	// a running primary match must give a trigger clock pulse in the next cycle
	property p_trig_pulse;
		@(posedge pclk) disable iff (!presetn)
			clk_en && mode != `MODE_OFF && st_r.ctrl_one[`TMR_EN_BIT] && pri_hit |=> trig_gen_clock;
	endproperty
	a_trig_pulse: assert property (p_trig_pulse) else $error("no trigger clock on primary match");

	// no pulse may appear without a primary match behind it
	property p_trig_quiet;
		@(posedge pclk) disable iff (!presetn) clk_en && !pri_hit |=> !trig_gen_clock;
	endproperty
	a_trig_quiet: assert property (p_trig_quiet) else $error("trigger clock without primary match");

	// edge pwm starts each period high
	property p_edge_high;
		@(posedge pclk) disable iff (!presetn)
			clk_en && mode == `MODE_PWM_EDGE && zero_hit && !pri_hit && !wr_ctrl |=> compare_output_pin;
	endproperty
	a_edge_high: assert property (p_edge_high) else $error("edge pwm not high at zero");

	// one-shot high variant rises on its primary match
	property p_shot_high;
		@(posedge pclk) disable iff (!presetn)
			clk_en && mode == `MODE_SS_HIGH && st_r.phase == PH_WAIT_PRI && pri_hit && !wr_ctrl
			|=> compare_output_pin;
	endproperty
	a_shot_high: assert property (p_shot_high) else $error("one-shot not forced high");

	// one-shot low variant falls on its primary match
	property p_shot_low;
		@(posedge pclk) disable iff (!presetn)
			clk_en && mode == `MODE_SS_LOW && st_r.phase == PH_WAIT_PRI && pri_hit && !wr_ctrl
			|=> !compare_output_pin;
	endproperty
	a_shot_low: assert property (p_shot_low) else $error("one-shot not forced low");

	// after the single edge the pin must hold, whatever the timer does
	property p_shot_hold;
		@(posedge pclk) disable iff (!presetn)
			clk_en && (mode == `MODE_SS_HIGH || mode == `MODE_SS_LOW) && st_r.phase == PH_DONE && !wr_ctrl
			|=> $stable(compare_output_pin);
	endproperty
	a_shot_hold: assert property (p_shot_hold) else $error("one-shot pin moved after its match");

	// single-shot double compare gives no second pulse
	property p_dc_stop;
		@(posedge pclk) disable iff (!presetn)
			clk_en && mode == `MODE_DC_SINGLE && st_r.phase == PH_DONE && !wr_ctrl |=> $stable(compare_output_pin);
	endproperty
	a_dc_stop: assert property (p_dc_stop) else $error("double single-shot pulsed again");

	// continuous double compare: the secondary edge rearms the primary wait
	sequence s_sec_match_cont;
		clk_en && mode == `MODE_DC_CONT && st_r.phase == PH_WAIT_SEC && sec_hit && !wr_ctrl;
	endsequence

	property p_dc_rearm;
		@(posedge pclk) disable iff (!presetn)
			s_sec_match_cont |=> st_r.phase == PH_WAIT_PRI && compare_output_pin != $past(compare_output_pin);
	endproperty
	a_dc_rearm: assert property (p_dc_rearm) else $error("continuous double compare did not rearm");

	// pwm: active compare values move only at the period start
	property p_pwm_buffer;
		@(posedge pclk) disable iff (!presetn)
			clk_en && pwm_mode && !zero_hit |=> $stable(st_r.pri_active) && $stable(st_r.sec_active);
	endproperty
	a_pwm_buffer: assert property (p_pwm_buffer) else $error("pwm compare value changed mid period");

	// outside pwm a primary write acts at once
	property p_direct_write;
		@(posedge pclk) disable iff (!presetn)
			clk_en && !pwm_mode && wr_acc && !st_r.rsp.pready && apb_req.paddr == `OFS_PRIMARY
			|=> st_r.pri_active == $past(apb_req.pwdata[15:0]);
	endproperty
	a_direct_write: assert property (p_direct_write) else $error("primary write not applied directly");

	// a low clock enable freezes every bit of state
	property p_freeze;
		@(posedge pclk) disable iff (!presetn) !clk_en |=> $stable(st_r);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");
endmodule // ocmp_channel

// >>> hw/ocmp_defines.svh
/*
 * register offsets, field positions, reset values and mode codes of the compare channel.
 * assumes inclusion by bare name from the package and the design file.
 */
`ifndef OCMP_DEFINES_SVH
`define OCMP_DEFINES_SVH

// byte offsets on apb
`define OFS_CTRL_ONE 12'h000
`define OFS_CTRL_TWO 12'h004
`define OFS_PRIMARY 12'h008
`define OFS_SECONDARY 12'h00C
`define OFS_TIMER 12'h010
`define OFS_IRQ_STAT 12'h014
`define OFS_IRQ_MASK 12'h018

// control one fields
`define MODE_LSB 0
`define MODE_MSB 2
`define TRIG_MODE_BIT 3
`define TMR_EN_BIT 4
// control two fields
`define TRIG_STAT_BIT 6

// mode codes
`define MODE_OFF 3'h0
`define MODE_SS_HIGH 3'h1
`define MODE_SS_LOW 3'h2
`define MODE_TOGGLE 3'h3
`define MODE_DC_SINGLE 3'h4
`define MODE_DC_CONT 3'h5
`define MODE_PWM_EDGE 3'h6
`define MODE_PWM_CENTER 3'h7

// interrupt status bits
`define IRQ_PRI_BIT 0
`define IRQ_SEC_BIT 1
`define IRQ_WIDTH 2

`define CTRL_RESET 16'h0000
`define TIMER_RESET 16'h0000

`endif

// >>> hw/ocmp_pkg.sv
/*
 * types for the compare channel.
 * assumes ocmp_defines.svh lies on the include path.
 */
package ocmp_pkg;
	`include "ocmp_defines.svh"

	// compare mode field
	typedef logic [2:0] mode_t;

	// apb request as one bundle
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	// apb answer bundle
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;

	// pulse sequencing phase
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_WAIT_PRI,
		PH_WAIT_SEC,
		PH_DONE
	} phase_t;

	// all state of the channel
	typedef struct packed {
		logic [15:0] ctrl_one;
		logic trig_stat;
		logic [15:0] pri_active;
		logic [15:0] sec_active;
		logic [15:0] pri_buf;
		logic [15:0] sec_buf;
		logic [15:0] timer;
		logic [`IRQ_WIDTH-1:0] irq_stat;
		logic [`IRQ_WIDTH-1:0] irq_mask;
		phase_t phase;
		logic out;
		logic trig_clk;
		logic irq;
		apb_rsp_t rsp;
	} state_t;
endpackage

// >>> test/ocmp_load.sv
/*
 * far-side load of the compare pin: counts rising pin edges and trigger clock pulses.
 * assumes pin and pulse are registered outputs of the channel on pclk.
 */
module ocmp_load (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pin,
	input wire logic trig,
	output int rises,
	output int pulses
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last_r; // previous pin level

	// edge and pulse counting; a passive load never drives back
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rises <= 0;
			pulses <= 0;
			last_r <= 1'b0;
		end else begin
			last_r <= pin;
			if (pin === 1'b1 && last_r === 1'b0) rises <= rises + 1;
			if (trig === 1'b1) pulses <= pulses + 1;
		end
	end
endmodule // ocmp_load

// >>> test/output_compare_mode_logic_tb_top.sv
/*
 * self-checking bench of the compare channel: apb master tasks and one task per scenario.
 * assumes the channel answers apb within a few cycles and clk_en may stay high.
 */
`include "ocmp_defines.svh"

module output_compare_mode_logic_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ocmp_pkg::*;
	logic pclk = 1'b0; // 200 MHz
	logic presetn = 1'b0; // active low
	apb_req_t req = '0; // master request
	apb_rsp_t rsp; // slave answer
	logic trig_set = 1'b0; // external status set
	logic clk_en = 1'b1; // dropped only in the freeze check
	logic pin, tgc, tflag, irq;
	logic [31:0] rd; // last read data
	logic perr; // last slave error
	int fails = 0, samples_checked = 0, cycles = 0, rises, pulses;

	ocmp_channel i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .apb_req(req), .apb_rsp(rsp),
		.trig_stat_set(trig_set), .compare_output_pin(pin), .trig_gen_clock(tgc),
		.trig_status_flag(tflag), .irq(irq));
	ocmp_load i_load (.pclk(pclk), .presetn(presetn), .pin(pin), .trig(tgc), .rises(rises), .pulses(pulses));

	always #2.5 pclk = ~pclk;
	// hang guard: whole run needs well under a thousand cycles
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one apb transfer; held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge pclk);
		req.penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 50);
		if (n >= 50) fails++;
		rd = rsp.prdata;
		perr = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	// bounded wait for a pin level
	task automatic waitp(input logic v);
		int n;
		n = 0;
		while (pin !== v && n < 100) begin
			@(posedge pclk);
			n++;
		end
		chk("pin", {31'h0, v}, {31'h0, pin});
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_regs();
		apb(1'b0, `OFS_CTRL_ONE, 32'h0);
		chk("ctrl reset", 32'h0, rd);
		wr(`OFS_CTRL_ONE, 32'h0000_0018);
		apb(1'b0, `OFS_CTRL_ONE, 32'h0);
		chk("ctrl rw", 32'h0000_0018, rd);
		apb(1'b0, 12'h0FC, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, perr});
		chk("unmapped data", 32'h0, rd);
	endtask

	task automatic t_shot();
		int p;
		wr(`OFS_PRIMARY, 32'h0000_0008);
		wr(`OFS_CTRL_ONE, 32'h0000_0002);
		chk("init high", 32'h1, {31'h0, pin});
		wr(`OFS_TIMER, 32'h0);
		wr(`OFS_CTRL_ONE, 32'h0000_0012);
		waitp(1'b0);
		// the load counts that match pulse one edge later
		@(posedge pclk);
		p = pulses;
		wr(`OFS_TIMER, 32'h0);
		wr(`OFS_CTRL_ONE, 32'h0000_0011);
		waitp(1'b1);
		@(posedge pclk);
		chk("trigger pulses", p + 1, pulses);
		wr(`OFS_CTRL_ONE, 32'h0000_0010);
		p = pulses;
		// park the timer on the primary value: a standing match must do nothing
		wr(`OFS_TIMER, 32'h0000_0008);
		repeat (20) @(posedge pclk);
		chk("off pin", 32'h0, {31'h0, pin});
		chk("off trigger", p, pulses);
		apb(1'b0, `OFS_TIMER, 32'h0);
		chk("off timer", 32'h0000_0008, rd);
	endtask

	task automatic t_toggle();
		wr(`OFS_PRIMARY, 32'h0000_0004);
		wr(`OFS_CTRL_ONE, 32'h0000_0003);
		wr(`OFS_TIMER, 32'h0);
		wr(`OFS_CTRL_ONE, 32'h0000_0013);
		waitp(1'b1);
		wr(`OFS_TIMER, 32'h0);
		waitp(1'b0);
	endtask

	// both double-compare modes give one clean pulse
	task automatic t_double();
		int r;
		for (int m = 4; m <= 5; m++) begin
			wr(`OFS_CTRL_ONE, m);
			chk("double init", 32'h0, {31'h0, pin});
			wr(`OFS_PRIMARY, 32'h0000_0004);
			wr(`OFS_SECONDARY, 32'h0000_0009);
			wr(`OFS_TIMER, 32'h0);
			r = rises;
			wr(`OFS_CTRL_ONE, 32'h10 | m);
			waitp(1'b1);
			waitp(1'b0);
			chk("one pulse", r + 1, rises);
			// restart the timer: continuous pulses again, single-shot stays quiet
			wr(`OFS_TIMER, 32'h0);
			repeat (20) @(posedge pclk);
			chk("rearm pulses", r + m - 3, rises);
		end
	endtask

	task automatic t_pwm();
		int r;
		wr(`OFS_CTRL_ONE, 32'h0000_0006);
		wr(`OFS_PRIMARY, 32'h0000_0004);
		wr(`OFS_SECONDARY, 32'h0000_000C);
		wr(`OFS_TIMER, 32'h0);
		r = rises;
		wr(`OFS_CTRL_ONE, 32'h0000_0016);
		repeat (60) @(posedge pclk);
		chk("edge pwm periods", 32'h1, {31'h0, (rises - r) >= 3});
		// freeze the running pwm: no edge may reach the load
		clk_en <= 1'b0;
		repeat (2) @(posedge pclk);
		r = rises;
		repeat (20) @(posedge pclk);
		chk("frozen rises", r, rises);
		clk_en <= 1'b1;
		@(posedge pclk);
		wr(`OFS_CTRL_ONE, 32'h0000_0007);
		wr(`OFS_PRIMARY, 32'h0000_0005);
		wr(`OFS_TIMER, 32'h0);
		wr(`OFS_CTRL_ONE, 32'h0000_0017);
		waitp(1'b1);
		waitp(1'b0);
	endtask

	// status flag, then the match interrupt under its mask
	task automatic t_trig();
		apb(1'b0, `OFS_IRQ_STAT, 32'h0);
		trig_set <= 1'b1;
		@(posedge pclk);
		trig_set <= 1'b0;
		wr(`OFS_PRIMARY, 32'h0000_0003);
		wr(`OFS_SECONDARY, 32'h0000_0006);
		wr(`OFS_TIMER, 32'h0);
		wr(`OFS_CTRL_ONE, 32'h0000_0015);
		repeat (20) @(posedge pclk);
		chk("flag held", 32'h1, {31'h0, tflag});
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(`OFS_IRQ_MASK, 32'h0000_0003);
		@(posedge pclk);
		chk("irq on", 32'h1, {31'h0, irq});
		apb(1'b0, `OFS_IRQ_STAT, 32'h0);
		chk("irq status", 32'h0000_0003, rd);
		@(posedge pclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		wr(`OFS_CTRL_TWO, 32'h0);
		chk("sw clear", 32'h0, {31'h0, tflag});
		trig_set <= 1'b1;
		@(posedge pclk);
		trig_set <= 1'b0;
		wr(`OFS_CTRL_ONE, 32'h0000_001D);
		wr(`OFS_TIMER, 32'h0);
		repeat (20) @(posedge pclk);
		chk("match clear", 32'h0, {31'h0, tflag});
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("pin reset", 32'h0, {31'h0, pin});
		t_regs();
		t_shot();
		t_toggle();
		t_double();
		t_pwm();
		t_trig();
		end_of_test();
	end
endmodule // output_compare_mode_logic_tb_top
